// File: lbm_pkg.sv
// Shared constants, carrier types and state encodings for the local bus master interface.
package lbm_pkg;
  localparam int          DATA_W      = 8;
  localparam int          WAIT_W      = 4;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [3:0]  WAIT_RESET  = 4'h0;
  localparam logic        ASYNC_RESET = 1'b0;
  localparam logic [1:0]  TM_OK       = 2'h0;
  localparam logic [3:0]  WAIT_ZERO   = 4'h0;
  localparam logic [3:0]  WAIT_ONE    = 4'h1;

  typedef struct packed {
    logic              asyncAck;
    logic [WAIT_W-1:0] waitCount;
  } lbm_cfg_t;

  typedef struct packed {
    logic              write;
    logic [DATA_W-1:0] data;
  } lbm_xfer_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_REQ  = 4'b0010,
    M_WAIT = 4'b0100,
    M_END  = 4'b1000
  } lbm_mst_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_WAIT  = 4'b0010,
    S_ALIGN = 4'b0100,
    S_ACK   = 4'b1000
  } lbm_slv_t;
endpackage

// File: lbm_clock_gen.sv
// Derives the double-rate phase and the symmetrical board clock from the two phase inputs.
`timescale 1ns/1ps
module lbm_clock_gen (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic earlyPhaseClock,
  input  wire logic latePhaseClock,
  output logic      phase20,
  output logic      boardClockOut
);
  import lbm_pkg::*;

  logic phase20_reg;
  logic phase20_next;
  logic board_reg;
  logic board_next;

  // The two inputs are half a period apart, so their difference runs at twice the rate.
  always_comb begin
    phase20_next = earlyPhaseClock ^ latePhaseClock;
    board_next   = board_reg;
    if (phase20_next && !phase20_reg) begin
      board_next = !board_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase20_reg <= 1'b0;
      board_reg   <= 1'b0;
    end else begin
      phase20_reg <= phase20_next;
      board_reg   <= board_next;
    end
  end

  assign phase20       = phase20_reg;
  assign boardClockOut = board_reg;

  chk_board_toggle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase20_next && !phase20_reg) |=> (board_reg != $past(board_reg)))
    else $error("Board clock did not toggle on a phase edge.");
endmodule

// File: lbm_local_bus.sv
// Local bus mastership, relinquish-and-retry and transfer acknowledge handling.
`timescale 1ns/1ps
// Contract
// - Request local bus low when mastership needed.
// - Wait for grant low before using bus.
// - Assert grant acknowledge once bus is owned.
// - Derive double-rate clock and symmetrical board clock.
// - Provide eight-bit bidirectional active-high data path.
// - Collision: fault and stop both driven low.
// - Hold stop low until bus release cycle.
// - Release fault shortly after address strobe rises.
// - Backplane error status drives fault low.
// - Read ends on acknowledge low, data latched.
// - Write ends when accessed device acknowledges low.
// - Drive acknowledge low for processor slave cycles.
// - Wait-state count applies to I/O ranges.
// - Acknowledge sync or async, sync after reset.
module lbm_local_bus (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              earlyPhaseClock,
  input  wire logic              latePhaseClock,
  output logic                   phase20,
  output logic                   boardClockOut,
  input  wire logic              mastReq,
  input  wire lbm_pkg::lbm_xfer_t mastXfer,
  output logic                   mastDone,
  output logic [7:0]             mastRdData,
  output logic                   localBusRequest_b,
  input  wire logic              localBusGrant_b,
  output logic                   grantAcknowledge_b,
  input  wire logic              addrStrobeIn_b,
  output logic                   addrStrobeOut_b,
  output logic                   addrStrobeOe,
  input  wire logic              xferAckIn_b,
  output logic                   xferAckOut_b,
  output logic                   xferAckOe,
  input  wire logic [7:0]        localDataIn,
  output logic [7:0]             localDataOut,
  output logic                   localDataOe,
  input  wire logic              slaveSelect,
  input  wire logic              ioRange,
  input  wire logic              slaveReady,
  input  wire logic              cfgLoad,
  input  wire lbm_pkg::lbm_cfg_t cfgIn,
  input  wire logic              incomingBackplane,
  input  wire logic              procToBackplane,
  input  wire logic              ackCycle,
  input  wire logic              transferModeHigh,
  input  wire logic              transferModeLow,
  input  wire logic              busReleaseCycle,
  output logic                   busFaultSignal_b,
  output logic                   stopRequest_b
);
  import lbm_pkg::*;

  lbm_mst_t  mst_reg, mst_next;
  logic      req_reg, req_next, gack_reg, gack_next;
  logic      asOut_reg, asOut_next, asOe_reg, asOe_next;
  logic      dOe_reg, dOe_next, done_reg, done_next;
  logic [7:0] dOut_reg, dOut_next, rd_reg, rd_next;
  logic      wr_reg, wr_next;

  lbm_slv_t  slv_reg, slv_next;
  logic [3:0] cnt_reg, cnt_next;
  logic      ackOut_reg, ackOut_next, ackOe_reg, ackOe_next;
  lbm_cfg_t  cfg_reg, cfg_next;

  logic      fault_reg, fault_next, stop_reg, stop_next;
  logic      procCycle, collision, tmError;

  lbm_clock_gen u_clk (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .earlyPhaseClock (earlyPhaseClock),
    .latePhaseClock  (latePhaseClock),
    .phase20         (phase20),
    .boardClockOut   (boardClockOut)
  );

  // Master tenure on the local bus for backplane or auxiliary requests.
  always_comb begin
    mst_next   = mst_reg;
    req_next   = req_reg;
    gack_next  = gack_reg;
    asOut_next = asOut_reg;
    asOe_next  = asOe_reg;
    dOe_next   = dOe_reg;
    dOut_next  = dOut_reg;
    rd_next    = rd_reg;
    wr_next    = wr_reg;
    done_next  = 1'b0;
    unique case (mst_reg)
      M_IDLE: begin
        if (mastReq) begin
          req_next  = 1'b0;
          wr_next   = mastXfer.write;
          dOut_next = mastXfer.data;
          mst_next  = M_REQ;
        end
      end
      // The strobe must be high too, or the processor's own cycle would be cut short.
      M_REQ: begin
        if (!localBusGrant_b && addrStrobeIn_b) begin
          gack_next  = 1'b0;
          asOut_next = 1'b0;
          asOe_next  = 1'b1;
          dOe_next   = wr_reg;
          mst_next   = M_WAIT;
        end
      end
      M_WAIT: begin
        if (!xferAckIn_b) begin
          if (!wr_reg) begin
            rd_next = localDataIn;
          end
          done_next  = 1'b1;
          asOut_next = 1'b1;
          dOe_next   = 1'b0;
          mst_next   = M_END;
        end
      end
      M_END: begin
        asOe_next = 1'b0;
        req_next  = 1'b1;
        gack_next = 1'b1;
        mst_next  = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_reg   <= M_IDLE;
      req_reg   <= 1'b1;
      gack_reg  <= 1'b1;
      asOut_reg <= 1'b1;
      asOe_reg  <= 1'b0;
      dOe_reg   <= 1'b0;
      dOut_reg  <= DATA_RESET;
      rd_reg    <= DATA_RESET;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      mst_reg   <= mst_next;
      req_reg   <= req_next;
      gack_reg  <= gack_next;
      asOut_reg <= asOut_next;
      asOe_reg  <= asOe_next;
      dOe_reg   <= dOe_next;
      dOut_reg  <= dOut_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      done_reg  <= done_next;
    end
  end

  // A processor cycle is only seen while this block is not the master.
  assign procCycle = !addrStrobeIn_b && (mst_reg == M_IDLE);
  assign collision = procCycle && procToBackplane && incomingBackplane;
  assign tmError   = procCycle && procToBackplane && ackCycle &&
                     ({transferModeHigh, transferModeLow} != TM_OK);

  // Relinquish-and-retry and backplane error signalling.
  always_comb begin
    fault_next = fault_reg;
    stop_next  = stop_reg;
    if (busReleaseCycle) begin
      stop_next = 1'b1;
    end
    if (!fault_reg && addrStrobeIn_b) begin
      fault_next = 1'b1;
    end
    if (collision) begin
      fault_next = 1'b0;
      stop_next  = 1'b0;
    end else if (tmError) begin
      fault_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_reg <= 1'b1;
      stop_reg  <= 1'b1;
    end else begin
      fault_reg <= fault_next;
      stop_reg  <= stop_next;
    end
  end

  // Slave acknowledge toward the processor, with wait states for I/O ranges.
  always_comb begin
    slv_next    = slv_reg;
    cnt_next    = cnt_reg;
    ackOut_next = ackOut_reg;
    ackOe_next  = ackOe_reg;
    cfg_next    = cfg_reg;
    if (cfgLoad) begin
      cfg_next = cfgIn;
    end
    unique case (slv_reg)
      S_IDLE: begin
        if (procCycle && slaveSelect && fault_reg && !collision) begin
          cnt_next = ioRange ? cfg_reg.waitCount : WAIT_ZERO;
          slv_next = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!fault_reg || addrStrobeIn_b) begin
          slv_next = S_IDLE;
        end else if (cnt_reg != WAIT_ZERO) begin
          cnt_next = cnt_reg - WAIT_ONE;
        end else if (slaveReady) begin
          if (cfg_reg.asyncAck) begin
            ackOut_next = 1'b0;
            ackOe_next  = 1'b1;
            slv_next    = S_ACK;
          end else begin
            slv_next = S_ALIGN;
          end
        end
      end
      // The sync path costs one cycle: S_ALIGN waits one ref_clk cycle, without looking at the board clock.
      S_ALIGN: begin
        ackOut_next = 1'b0;
        ackOe_next  = 1'b1;
        slv_next    = S_ACK;
      end
      S_ACK: begin
        if (addrStrobeIn_b) begin
          ackOut_next = 1'b1;
          ackOe_next  = 1'b0;
          slv_next    = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      slv_reg    <= S_IDLE;
      cnt_reg    <= WAIT_RESET;
      ackOut_reg <= 1'b1;
      ackOe_reg  <= 1'b0;
      cfg_reg    <= '{asyncAck: ASYNC_RESET, waitCount: WAIT_RESET};
    end else begin
      slv_reg    <= slv_next;
      cnt_reg    <= cnt_next;
      ackOut_reg <= ackOut_next;
      ackOe_reg  <= ackOe_next;
      cfg_reg    <= cfg_next;
    end
  end

  assign mastDone           = done_reg;
  assign mastRdData         = rd_reg;
  assign localBusRequest_b  = req_reg;
  assign grantAcknowledge_b = gack_reg;
  assign addrStrobeOut_b    = asOut_reg;
  assign addrStrobeOe       = asOe_reg;
  assign xferAckOut_b       = ackOut_reg;
  assign xferAckOe          = ackOe_reg;
  assign localDataOut       = dOut_reg;
  assign localDataOe        = dOe_reg;
  assign busFaultSignal_b   = fault_reg;
  assign stopRequest_b      = stop_reg;

  sequence seq_tenure_end;
    (mst_reg == M_END) ##1 (req_reg && gack_reg && !asOe_reg);
  endsequence

  sequence seq_sync_ack;
    (slv_reg == S_ALIGN) ##1 (!ackOut_reg && ackOe_reg);
  endsequence

  chk_request_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mst_reg == M_IDLE && mastReq) |=> (!req_reg && mst_reg == M_REQ))
    else $error("Bus request not driven low on need.");
  chk_grant_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(gack_reg) |-> $past(!localBusGrant_b && !req_reg))
    else $error("Grant acknowledged without grant.");
  chk_owned_ack: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mst_reg == M_WAIT) |-> (!gack_reg && asOe_reg && !asOut_reg))
    else $error("Owned bus without grant acknowledge.");
  chk_collision_both: assert property (@(posedge ref_clk) disable iff (!rst_b)
    collision |=> (!fault_reg && !stop_reg))
    else $error("Collision did not force retry.");
  chk_stop_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!stop_reg && !busReleaseCycle) |=> !stop_reg)
    else $error("Stop released before bus release cycle.");
  chk_fault_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!fault_reg && addrStrobeIn_b && !collision && !tmError) |=> fault_reg)
    else $error("Fault not released after strobe rose.");
  chk_tm_error: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tmError |=> !fault_reg)
    else $error("Error status did not raise bus fault.");
  chk_read_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mst_reg == M_WAIT && !xferAckIn_b && !wr_reg) |=>
      (done_reg && rd_reg == $past(localDataIn)))
    else $error("Read data not latched on acknowledge.");
  chk_write_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mst_reg == M_WAIT && !xferAckIn_b) |=> (mst_reg == M_END && asOut_reg && !dOe_reg))
    else $error("Cycle not ended on acknowledge.");
  chk_wait_states: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slv_reg == S_WAIT && cnt_reg != WAIT_ZERO && fault_reg && !addrStrobeIn_b) |=>
      !ackOe_reg)
    else $error("Acknowledge before wait states elapsed.");
  chk_sync_path: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slv_reg == S_WAIT && cnt_reg == WAIT_ZERO && slaveReady && fault_reg &&
     !addrStrobeIn_b && !cfg_reg.asyncAck) |=> seq_sync_ack)
    else $error("Sync acknowledge timing wrong.");
  chk_ack_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slv_reg == S_ACK && addrStrobeIn_b) |=> (!ackOe_reg && slv_reg == S_IDLE))
    else $error("Acknowledge not released after strobe.");
  chk_tenure_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mst_reg == M_WAIT && !xferAckIn_b) |=> seq_tenure_end)
    else $error("Tenure end did not release bus.");
endmodule

// File: lbm_proc_model.sv
// Far-side model: processor bus arbitration, on-card memory and the two phase clocks.
`timescale 1ns/1ps
module lbm_proc_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       localBusRequest_b,
  input  wire logic       grantAcknowledge_b,
  input  wire logic       addrStrobe_b,
  input  wire logic       dutAsOe,
  input  wire logic       dutDataOe,
  input  wire logic [7:0] localData,
  input  wire logic [7:0] memValue,
  input  wire logic [3:0] grantWait,
  output logic            localBusGrant_b,
  output logic            memAck_b,
  output logic            memAckOe,
  output logic [7:0]      memData,
  output logic            memDataOe,
  output logic [7:0]      lastWrite,
  output logic            earlyPhaseClock,
  output logic            latePhaseClock
);
  logic [3:0] grantCnt;

  // Phases sit 10 ns off ref_clk so no phase edge lands on a sampling edge.
  initial begin
    earlyPhaseClock = 1'b1;
    latePhaseClock = 1'b1;
    #10;
    forever begin
      earlyPhaseClock = 1'b0;
      #25 earlyPhaseClock = 1'b1;
      #25 latePhaseClock = 1'b0;
      #25 latePhaseClock = 1'b1;
      #25;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      localBusGrant_b <= 1'b1;
      grantCnt <= 4'h0;
      memAck_b <= 1'b1;
      memAckOe <= 1'b0;
      memDataOe <= 1'b0;
      memData <= 8'h00;
      lastWrite <= 8'h00;
    end else begin
      if (!localBusRequest_b && grantCnt == grantWait) begin
        localBusGrant_b <= 1'b0;
      end else if (!localBusRequest_b) begin
        grantCnt <= grantCnt + 4'h1;
      end else if (grantAcknowledge_b) begin
        localBusGrant_b <= 1'b1;
        grantCnt <= 4'h0;
      end
      if (!addrStrobe_b && dutAsOe && !memAckOe) begin
        memAckOe <= 1'b1;
        memAck_b <= 1'b0;
        if (dutDataOe) begin
          lastWrite <= localData;
        end else begin
          memDataOe <= 1'b1;
          memData <= memValue;
        end
      end else if (addrStrobe_b) begin
        memAckOe <= 1'b0;
        memDataOe <= 1'b0;
      end
    end
  end
endmodule

// File: tb_local_bus_master_interface.sv
// Self-checking testbench for the local bus master interface.
`timescale 1ns/1ps
module tb_local_bus_master_interface;
  import lbm_pkg::*;
  logic ref_clk, rst_b, earlyPhaseClock, latePhaseClock, phase20, boardClockOut;
  logic mastReq, mastDone, localBusRequest_b, localBusGrant_b, grantAcknowledge_b;
  logic addrStrobeOut_b, addrStrobeOe, xferAckOut_b, xferAckOe, localDataOe;
  logic slaveSelect, ioRange, slaveReady, cfgLoad, incomingBackplane, procToBackplane;
  logic ackCycle, transferModeHigh, transferModeLow, busReleaseCycle;
  logic busFaultSignal_b, stopRequest_b, tbAs_b, tbAsOe, memAck_b, memAckOe, memDataOe;
  logic asWire, ackWire;
  logic [7:0] mastRdData, localDataOut, memData, memValue, lastWrite, dataWire;
  logic [7:0] lastData = 8'h00;
  logic [3:0] grantWait;
  lbm_xfer_t mastXfer;
  lbm_cfg_t  cfgIn;
  int n_errors = 0;
  int compares = 0;

  // Strobe and acknowledge carry pull-ups; the data wire has none, so it shows junk when idle.
  assign asWire = addrStrobeOe ? addrStrobeOut_b : (tbAsOe ? tbAs_b : 1'b1);
  assign ackWire = xferAckOe ? xferAckOut_b : (memAckOe ? memAck_b : 1'b1);
  assign dataWire = localDataOe ? localDataOut : (memDataOe ? memData : ~lastData);
  always @(posedge ref_clk) lastData <= dataWire;

  lbm_local_bus dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .earlyPhaseClock(earlyPhaseClock),
    .latePhaseClock(latePhaseClock), .phase20(phase20), .boardClockOut(boardClockOut),
    .mastReq(mastReq), .mastXfer(mastXfer), .mastDone(mastDone), .mastRdData(mastRdData),
    .localBusRequest_b(localBusRequest_b), .localBusGrant_b(localBusGrant_b),
    .grantAcknowledge_b(grantAcknowledge_b), .addrStrobeIn_b(asWire),
    .addrStrobeOut_b(addrStrobeOut_b), .addrStrobeOe(addrStrobeOe), .xferAckIn_b(ackWire),
    .xferAckOut_b(xferAckOut_b), .xferAckOe(xferAckOe), .localDataIn(dataWire),
    .localDataOut(localDataOut), .localDataOe(localDataOe), .slaveSelect(slaveSelect),
    .ioRange(ioRange), .slaveReady(slaveReady), .cfgLoad(cfgLoad), .cfgIn(cfgIn),
    .incomingBackplane(incomingBackplane), .procToBackplane(procToBackplane),
    .ackCycle(ackCycle), .transferModeHigh(transferModeHigh),
    .transferModeLow(transferModeLow), .busReleaseCycle(busReleaseCycle),
    .busFaultSignal_b(busFaultSignal_b), .stopRequest_b(stopRequest_b));

  lbm_proc_model proc_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .localBusRequest_b(localBusRequest_b),
    .grantAcknowledge_b(grantAcknowledge_b), .addrStrobe_b(asWire), .dutAsOe(addrStrobeOe),
    .dutDataOe(localDataOe), .localData(dataWire), .memValue(memValue),
    .grantWait(grantWait), .localBusGrant_b(localBusGrant_b), .memAck_b(memAck_b),
    .memAckOe(memAckOe), .memData(memData), .memDataOe(memDataOe), .lastWrite(lastWrite),
    .earlyPhaseClock(earlyPhaseClock), .latePhaseClock(latePhaseClock));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task tick;
    @(posedge ref_clk);
    #1;
  endtask

  task complete_run;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function logic pick(input int s);
    case (s)
      0: pick = localBusRequest_b;
      1: pick = grantAcknowledge_b;
      2: pick = mastDone;
      3: pick = ackWire;
      4: pick = busFaultSignal_b;
      5: pick = stopRequest_b;
      default: pick = xferAckOe;
    endcase
  endfunction

  // Counts edges until the picked signal reaches lvl; a bound of 40 cuts a hang short.
  task waitFor(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) !== lvl && n < 40) begin
      tick;
      n++;
    end
    if (n >= 40) begin
      n_errors++;
      $display("CHECK FAILED wait %0d expected %b seen %b", s, lvl, pick(s));
      complete_run;
    end
  endtask

  task testMaster(input logic wr, input logic [7:0] d);
    int n;
    mastReq = 1'b1;
    mastXfer = '{write: wr, data: d};
    tick;
    mastReq = 1'b0;
    waitFor(0, 1'b0, n);
    for (int i = 0; i < 10 && localBusGrant_b; i++) begin
      chk("gackEarly", grantAcknowledge_b, 1'b1);
      tick;
    end
    waitFor(1, 1'b0, n);
    waitFor(2, 1'b1, n);
    if (wr)
      chk("written", lastWrite, d);
    else
      chk("readData", mastRdData, memValue);
    waitFor(1, 1'b1, n);
    chk("releaseLag", 8'(n), 8'h01);
    chk("request", localBusRequest_b, 1'b1);
    $display("test master done");
  endtask

  task slaveCycle(input logic io, output int n);
    int m;
    tbAsOe = 1'b1;
    tbAs_b = 1'b0;
    slaveSelect = 1'b1;
    slaveReady = 1'b1;
    ioRange = io;
    waitFor(3, 1'b0, n);
    tbAs_b = 1'b1;
    tbAsOe = 1'b0;
    slaveSelect = 1'b0;
    waitFor(6, 1'b0, m);
    chk("ackRelease", 8'(m), 8'h01);
    tick;
  endtask

  task testSlave;
    int nSync, nAsync, nIo;
    slaveCycle(1'b0, nSync);
    chk("syncLatency", 8'(nSync), 8'h03);
    cfgIn = '{asyncAck: 1'b1, waitCount: 4'h2};
    cfgLoad = 1'b1;
    tick;
    cfgLoad = 1'b0;
    slaveCycle(1'b0, nAsync);
    chk("asyncLatency", 8'(nAsync), 8'(nSync - 1));
    slaveCycle(1'b1, nIo);
    chk("ioWaits", 8'(nIo - nAsync), 8'h02);
    $display("test slave done");
  endtask

  task testRetry;
    int n;
    tbAsOe = 1'b1;
    tbAs_b = 1'b0;
    slaveSelect = 1'b1;
    procToBackplane = 1'b1;
    incomingBackplane = 1'b1;
    waitFor(4, 1'b0, n);
    chk("collisionLag", 8'(n), 8'h01);
    chk("stopLow", stopRequest_b, 1'b0);
    chk("noSlaveAck", xferAckOe, 1'b0);
    tbAs_b = 1'b1;
    tbAsOe = 1'b0;
    slaveSelect = 1'b0;
    incomingBackplane = 1'b0;
    waitFor(4, 1'b1, n);
    chk("faultLag", 8'(n), 8'h01);
    repeat (3) tick;
    chk("stopHeld", stopRequest_b, 1'b0);
    busReleaseCycle = 1'b1;
    tick;
    busReleaseCycle = 1'b0;
    chk("stopFree", stopRequest_b, 1'b1);
    procToBackplane = 1'b0;
    $display("test retry done");
  endtask

  task testFault;
    int n;
    for (int m = 0; m < 4; m++) begin
      tbAsOe = 1'b1;
      tbAs_b = 1'b0;
      procToBackplane = 1'b1;
      ackCycle = 1'b1;
      {transferModeHigh, transferModeLow} = 2'(m);
      tick;
      ackCycle = 1'b0;
      chk("modeFault", busFaultSignal_b, 1'(m == 0));
      chk("modeStop", stopRequest_b, 1'b1);
      tbAs_b = 1'b1;
      tbAsOe = 1'b0;
      procToBackplane = 1'b0;
      waitFor(4, 1'b1, n);
      tick;
    end
    $display("test fault done");
  endtask

  initial begin
    rst_b = 1'b0;
    {mastReq, slaveSelect, ioRange, slaveReady, cfgLoad, incomingBackplane} = 6'h00;
    {procToBackplane, ackCycle, transferModeHigh, transferModeLow, busReleaseCycle} = 5'h00;
    mastXfer = '0;
    cfgIn = '0;
    tbAs_b = 1'b1;
    tbAsOe = 1'b0;
    memValue = 8'h5a;
    grantWait = 4'h3;
    repeat (8) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    chk("resetRequest", localBusRequest_b, 1'b1);
    chk("resetFault", busFaultSignal_b, 1'b1);
    chk("resetBoard", boardClockOut, 1'b0);
    tick;
    chk("phase20", phase20, earlyPhaseClock ^ latePhaseClock);
    testMaster(1'b0, 8'h00);
    testMaster(1'b1, 8'ha5);
    testSlave;
    testRetry;
    testFault;
    complete_run;
  end
endmodule
